// [hdl/gsr_pkg.sv]
// Shared constants, types and helpers of the gain switch and filter block
package gsr_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_NS = 50_000;
  localparam int SAMPLE_CYCLES = SAMPLE_NS / CLK_PERIOD_NS;
  // Sample period in 0.01 ms units
  localparam logic [15:0] SAMPLE_TC = 16'(SAMPLE_NS / 10_000);
  // 2*pi*65536*Ts per hertz, rounded, for the 20 kHz sample rate
  localparam logic [16:0] FREQ_COEF = 17'h0_0015;
  // 65536 / 100, turns a depth in percent into a Q16 factor
  localparam logic [16:0] DEPTH_COEF = 17'h0_028f;
  // Time constants: torque filter 0.01 ms, integral 0.1 ms units
  localparam logic [15:0] LPF_TC_FIRST_MIN = 16'h000a;
  localparam logic [15:0] LPF_TC_SECOND_MIN = 16'h0001;
  localparam logic [15:0] LPF_TC_MAX = 16'h1388;
  localparam logic [15:0] LPF_TC_FIRST_DEF = 16'h00c8;
  localparam logic [15:0] INTEG_TC_MIN = 16'h000a;
  localparam logic [15:0] INTEG_TC_MAX = 16'h2710;
  localparam logic [15:0] INTEG_TC_FIRST_DEF = 16'h00c8;
  localparam logic [15:0] SPEED_GAIN_DEF = 16'h0028;
  localparam logic [15:0] POS_GAIN_DEF = 16'h0028;
  localparam logic [15:0] NOTCH_FREQ_MIN = 16'h0032;
  localparam logic [15:0] NOTCH_FREQ_MAX = 16'h0bb8;
  localparam logic [15:0] NOTCH_Q_MIN = 16'h0001;
  localparam logic [15:0] NOTCH_Q_MAX = 16'h0064;
  localparam logic [15:0] NOTCH_DEPTH_MAX = 16'h0064;
  localparam logic [16:0] LPF_COEF_RST =
    17'((32'(SAMPLE_TC) << 16) / (32'(LPF_TC_FIRST_DEF) + 32'(SAMPLE_TC)));

  typedef enum logic [2:0] {
    SEL_FIRST = 3'b000,
    SEL_SECOND = 3'b001,
    SEL_INPUT = 3'b010,
    SEL_FREQ = 3'b011,
    SEL_DEVIATION = 3'b100,
    SEL_SPEED = 3'b101
  } gsr_sel_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RAMP = 1'b1
  } gsr_state_e;

  function automatic logic [15:0] gsr_clamp(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
endpackage

// [hdl/gsr_notch_if.sv]
// Settings and sample stream of one notch stage
`timescale 1ns/10ps
`default_nettype none
interface gsr_notch_if;
  logic [11:0] freq;
  logic [6:0] quality;
  logic [6:0] depth;
  logic inValid;
  logic signed [15:0] inData;
  logic outValid;
  logic signed [15:0] outData;
  modport feed(output freq, quality, depth, inValid, inData,
               input outValid, outData);
  modport filt(input freq, quality, depth, inValid, inData,
               output outValid, outData);
endinterface
`default_nettype wire

// [hdl/gsr_notch_filter.sv]
// One notch stage built as a state-variable filter
`timescale 1ns/10ps
`default_nettype none
module gsr_notch_filter
  import gsr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  gsr_notch_if.filt port
);
  logic signed [23:0] low;
  logic signed [23:0] band;

  wire [15:0] freqC = gsr_clamp(16'(port.freq), NOTCH_FREQ_MIN,
                                NOTCH_FREQ_MAX);
  wire [16:0] fCoef = 17'(17'(freqC) * FREQ_COEF);
  // damping is 1/Q, so a small Q gives a wide band
  wire [15:0] qualC = gsr_clamp(16'(port.quality), NOTCH_Q_MIN,
                                NOTCH_Q_MAX);
  wire [16:0] qCoef = 17'(32'h0001_0000 / 32'(qualC));
  wire [15:0] depthC = gsr_clamp(16'(port.depth), 16'h0000,
                                 NOTCH_DEPTH_MAX);
  wire [16:0] dCoef = 17'(17'(depthC) * DEPTH_COEF);

  wire signed [23:0] x = 24'(port.inData);
  wire signed [41:0] fBand = band * $signed({1'b0, fCoef});
  wire signed [23:0] lowN = low + 24'(fBand >>> 16);
  wire signed [41:0] qBand = band * $signed({1'b0, qCoef});
  wire signed [23:0] qBandS = 24'(qBand >>> 16);
  wire signed [23:0] high = x - lowN - qBandS;
  wire signed [41:0] fHigh = high * $signed({1'b0, fCoef});
  wire signed [23:0] bandN = band + 24'(fHigh >>> 16);
  // depth scales the removed band; zero depth passes the input
  wire signed [41:0] cut = qBandS * $signed({1'b0, dCoef});
  wire signed [23:0] y = x - 24'(cut >>> 16);
  wire overTop = y > 24'sh00_7fff;
  wire underBot = y < 24'shff_8000;
  wire signed [15:0] ySat = overTop ? 16'sh7fff :
                            (underBot ? 16'sh8000 : y[15:0]);

  always_ff @(posedge clock) begin
    if (rst) begin
      low <= '0;
      band <= '0;
      port.outValid <= 1'b0;
      port.outData <= '0;
    end else begin
      port.outValid <= port.inValid;
      if (port.inValid) begin
        low <= lowN;
        band <= bandN;
        port.outData <= ySat;
      end
    end
  end

  passThrough_a: assert property (
    @(posedge clock) disable iff (rst)
    port.inValid && port.depth == 7'h00 |=>
      port.outValid && port.outData == $past(port.inData))
    else $error("notch with zero depth altered the sample");
endmodule
`default_nettype wire

// [hdl/gsr_gain_switch_filter.sv]
// Torque filter chain with two-set gain switching
//
// Operation
// - one torque filter constant, from active set
// - filter always active; second set 0.01 ms minimum
// - two notches together, 50 to 3000 Hz
// - notches pass through while their depth input is 0
// - quality 1 to 100; lower widens band
// - four gains per set switch together
// - selector 0 first, 1 second, 2 input
// - selector 3 compares command pulse frequency
// - selector 4 compares position deviation magnitude
// - selector 5 compares motor speed magnitude
// - condition true targets second, false first
// - change must persist beyond the delay
// - linear simultaneous ramp over switching time
// - comparator releases at or below level minus hysteresis
// - integral maximum disables speed integration
`timescale 1ns/10ps
`default_nettype none
module gsr_gain_switch_filter
  import gsr_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_CYCLES
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic signed [15:0] torqueIn,
  input wire logic [15:0] speedGainFirst,
  input wire logic [15:0] speedIntegralTcFirst,
  input wire logic [15:0] torqueLpfTcFirst,
  input wire logic [15:0] posGainFirst,
  input wire logic [15:0] speedGainSecond,
  input wire logic [15:0] speedIntegralTcSecond,
  input wire logic [15:0] torqueLpfTcSecond,
  input wire logic [15:0] posGainSecond,
  input wire logic [11:0] notchAFreq,
  input wire logic [6:0] notchAQuality,
  input wire logic [6:0] notchADepth,
  input wire logic [11:0] notchBFreq,
  input wire logic [6:0] notchBQuality,
  input wire logic [6:0] notchBDepth,
  input wire logic [2:0] gainSwitchSelect,
  input wire logic [14:0] gainSwitchThreshold,
  input wire logic [14:0] gainSwitchHysteresis,
  input wire logic [11:0] gainSwitchQualifyDelay,
  input wire logic [11:0] gainSwitchRampTime,
  input wire logic gainInput,
  input wire logic [15:0] cmdPulseFreq,
  input wire logic signed [15:0] posDeviation,
  input wire logic signed [15:0] motorSpeed,
  output logic [15:0] speedGain,
  output logic [15:0] speedIntegralTc,
  output logic [15:0] torqueLpfTc,
  output logic [15:0] posGain,
  output logic integralOff,
  output logic secondActive,
  output logic rampBusy,
  output logic signed [15:0] torqueOut,
  output logic torqueOutValid
);
  localparam logic [15:0] MS_LAST = 16'(CYCLES_PER_MS - 1);
  localparam logic [11:0] SAMPLE_LAST = 12'(SAMPLE_CYCLES - 1);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Pin synchroniser and time bases
  logic gainSync1;
  logic gainSync2;
  logic [15:0] msCount;
  logic msTick;
  logic [11:0] sampleCount;
  logic sampleTick;
  wire msWrap = msCount == MS_LAST;
  wire sampleWrap = sampleCount == SAMPLE_LAST;

  always_ff @(posedge clock) begin
    if (rst) begin
      gainSync1 <= 1'b0;
      gainSync2 <= 1'b0;
      msCount <= '0;
      msTick <= 1'b0;
      sampleCount <= '0;
      sampleTick <= 1'b0;
    end else begin
      gainSync1 <= gainInput;
      gainSync2 <= gainSync1;
      msCount <= msWrap ? 16'h0000 : msCount + 16'h0001;
      msTick <= msWrap;
      sampleCount <= sampleWrap ? 12'h000 : sampleCount + 12'h001;
      sampleTick <= sampleWrap;
    end
  end

  // Level comparator with hysteresis
  logic condLatch;
  gsr_sel_e selMode;
  assign selMode = gsr_sel_e'(gainSwitchSelect);
  wire [15:0] devMag = posDeviation[15] ? 16'(-posDeviation)
                                        : 16'(posDeviation);
  wire [15:0] speedMag = motorSpeed[15] ? 16'(-motorSpeed)
                                        : 16'(motorSpeed);
  wire [15:0] levelValue = (selMode == SEL_FREQ) ? cmdPulseFreq :
                           (selMode == SEL_DEVIATION) ? devMag : speedMag;
  wire [15:0] threshold = {1'b0, gainSwitchThreshold};
  wire [15:0] hysteresis = {1'b0, gainSwitchHysteresis};
  // release level sits hysteresis below the switching level
  wire [15:0] lowerLevel = (threshold > hysteresis) ?
                           threshold - hysteresis : 16'h0000;
  wire overLevel = levelValue > threshold;
  wire underLevel = levelValue <= lowerLevel;
  wire compareMode = selMode == SEL_FREQ || selMode == SEL_DEVIATION ||
                     selMode == SEL_SPEED;

  always_ff @(posedge clock) begin
    if (rst || !compareMode) begin
      condLatch <= 1'b0;
    end else if (overLevel) begin
      condLatch <= 1'b1;
    end else if (underLevel) begin
      condLatch <= 1'b0;
    end
  end

  wire rawTarget = (selMode == SEL_SECOND) ? 1'b1 :
                   (selMode == SEL_INPUT) ? gainSync2 :
                   compareMode ? condLatch : 1'b0;

  // qualify a change over whole millisecond ticks
  logic [11:0] qualCount;
  wire changePending = rawTarget != secondActive;
  wire qualDone = msTick && changePending &&
                  qualCount >= gainSwitchQualifyDelay;

  always_ff @(posedge clock) begin
    if (rst) begin
      secondActive <= 1'b0;
      qualCount <= '0;
    end else if (!changePending) begin
      qualCount <= '0;
    end else if (qualDone) begin
      secondActive <= rawTarget;
      qualCount <= '0;
    end else if (msTick) begin
      qualCount <= qualCount + 12'h001;
    end
  end

  logic [15:0] firstSet [4];
  logic [15:0] secondSet [4];
  logic [15:0] setVal [4];
  logic [15:0] applied [4];
  logic [15:0] startVal [4];
  logic [15:0] lerpVal [4];
  logic [15:0] next_applied [4];
  assign firstSet[0] = speedGainFirst;
  assign firstSet[1] = gsr_clamp(speedIntegralTcFirst, INTEG_TC_MIN,
                                 INTEG_TC_MAX);
  assign firstSet[2] = gsr_clamp(torqueLpfTcFirst, LPF_TC_FIRST_MIN,
                                 LPF_TC_MAX);
  assign firstSet[3] = posGainFirst;
  assign secondSet[0] = speedGainSecond;
  assign secondSet[1] = gsr_clamp(speedIntegralTcSecond, INTEG_TC_MIN,
                                  INTEG_TC_MAX);
  assign secondSet[2] = gsr_clamp(torqueLpfTcSecond, LPF_TC_SECOND_MIN,
                                  LPF_TC_MAX);
  assign secondSet[3] = posGainSecond;

  // Ramp control
  gsr_state_e state;
  logic [11:0] elapsed;
  wire [11:0] elapsedNext = elapsed + 12'h001;
  wire rampFinal = elapsedNext >= gainSwitchRampTime;
  wire [11:0] rampDiv = (gainSwitchRampTime == 12'h000) ? 12'h001
                                                         : gainSwitchRampTime;
  wire [31:0] fracWide = {4'h0, elapsedNext, 16'h0000} / 32'(rampDiv);
  wire [16:0] rampFrac = fracWide[16:0];
  wire rampStart = qualDone && gainSwitchRampTime != 12'h000;

  // all four values interpolate on the same fraction
  for (genvar i = 0; i < 4; i++) begin : gLerp
    wire signed [16:0] diff = 17'(setVal[i]) - 17'(startVal[i]);
    wire signed [34:0] prod = diff * $signed({1'b0, rampFrac});
    wire signed [17:0] step = 18'(prod >>> 16);
    assign setVal[i] = secondActive ? secondSet[i] : firstSet[i];
    assign lerpVal[i] = 16'(18'(startVal[i]) + step);
    assign next_applied[i] = (state == ST_IDLE) ? setVal[i] :
                             !msTick ? applied[i] :
                             rampFinal ? setVal[i] : lerpVal[i];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      rampBusy <= 1'b0;
      elapsed <= '0;
    end else if (rampStart) begin
      state <= ST_RAMP;
      rampBusy <= 1'b1;
      elapsed <= '0;
    end else if (state == ST_RAMP && msTick) begin
      state <= rampFinal ? ST_IDLE : ST_RAMP;
      rampBusy <= !rampFinal;
      elapsed <= elapsedNext;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      applied <= '{SPEED_GAIN_DEF, INTEG_TC_FIRST_DEF, LPF_TC_FIRST_DEF,
                   POS_GAIN_DEF};
      startVal <= '{SPEED_GAIN_DEF, INTEG_TC_FIRST_DEF, LPF_TC_FIRST_DEF,
                    POS_GAIN_DEF};
      integralOff <= 1'b0;
    end else begin
      applied <= next_applied;
      if (rampStart) begin
        startVal <= next_applied;
      end
      // integral time at its maximum stops integration
      integralOff <= next_applied[1] >= INTEG_TC_MAX;
    end
  end

  assign speedGain = applied[0];
  assign speedIntegralTc = applied[1];
  assign torqueLpfTc = applied[2];
  assign posGain = applied[3];

  // coefficient recomputed from the applied constant
  logic [16:0] lpfCoef;
  logic signed [31:0] lpfState;
  logic lpfValid;
  wire [31:0] lpfDiv = (32'(SAMPLE_TC) << 16) /
                       (32'(applied[2]) + 32'(SAMPLE_TC));
  wire signed [32:0] lpfErr = {torqueIn[15], torqueIn, 16'h0000} -
                              {lpfState[31], lpfState};
  wire signed [50:0] lpfProd = lpfErr * $signed({1'b0, lpfCoef});

  // low-pass stage sits in the path from reset on
  always_ff @(posedge clock) begin
    if (rst) begin
      lpfCoef <= LPF_COEF_RST;
      lpfState <= '0;
      lpfValid <= 1'b0;
    end else begin
      lpfCoef <= lpfDiv[16:0];
      lpfValid <= sampleTick;
      if (sampleTick) begin
        lpfState <= lpfState + 32'(lpfProd >>> 16);
      end
    end
  end

  gsr_notch_if notchA();
  gsr_notch_if notchB();
  assign notchA.freq = notchAFreq;
  assign notchA.quality = notchAQuality;
  assign notchA.depth = notchADepth;
  assign notchA.inValid = lpfValid;
  assign notchA.inData = lpfState[31:16];
  assign notchB.freq = notchBFreq;
  assign notchB.quality = notchBQuality;
  assign notchB.depth = notchBDepth;
  assign notchB.inValid = notchA.outValid;
  assign notchB.inData = notchA.outData;

  gsr_notch_filter uNotchA (
    .clock(clock),
    .rst(rst),
    .port(notchA.filt)
  );
  gsr_notch_filter uNotchB (
    .clock(clock),
    .rst(rst),
    .port(notchB.filt)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      torqueOut <= '0;
      torqueOutValid <= 1'b0;
    end else begin
      torqueOutValid <= notchB.outValid;
      if (notchB.outValid) begin
        torqueOut <= notchB.outData;
      end
    end
  end

  fixedSel_a: assert property (
    selMode == SEL_FIRST && !secondActive |=> !secondActive)
    else $error("fixed first selection left the first set");
  inputSel_a: assert property (
    selMode == SEL_INPUT |-> rawTarget == gainSync2)
    else $error("input selection ignores the gain input");
  freqCond_a: assert property (
    selMode == SEL_FREQ && $stable(selMode) && cmdPulseFreq > threshold
      |=> condLatch)
    else $error("pulse frequency above level not detected");
  devCond_a: assert property (
    selMode == SEL_DEVIATION && $stable(selMode) && devMag > threshold
      |=> condLatch)
    else $error("deviation above level not detected");
  speedCond_a: assert property (
    selMode == SEL_SPEED && $stable(selMode) && speedMag > threshold
      |=> condLatch)
    else $error("speed above level not detected");
  hystHold_a: assert property (
    condLatch && compareMode && $stable(selMode) &&
    levelValue > lowerLevel |=> condLatch)
    else $error("comparator released inside the hysteresis band");
  qualDelay_a: assert property (
    $changed(secondActive) |-> $past(qualDone) && $past(msTick))
    else $error("target set changed without qualification");
  targetSet_a: assert property (
    $changed(secondActive) |-> secondActive == $past(rawTarget))
    else $error("target set differs from the condition");
  rampEnd_a: assert property (
    rampBusy && msTick && rampFinal && !rampStart |=>
      !rampBusy && torqueLpfTc == $past(setVal[2]) &&
      posGain == $past(setVal[3]))
    else $error("ramp did not land on the target set");
  integOff_a: assert property (
    integralOff == (speedIntegralTc >= INTEG_TC_MAX))
    else $error("integration disable out of step");
  coefTrack_a: assert property (
    $changed(torqueLpfTc) |=> lpfCoef == 17'((32'(SAMPLE_TC) << 16) /
      (32'($past(torqueLpfTc)) + 32'(SAMPLE_TC))))
    else $error("filter coefficient did not follow the constant");
  lpfRun_a: assert property (
    sampleTick |=> lpfValid ##2 notchB.outValid ##1 torqueOutValid)
    else $error("sample did not pass the filter chain");

  rampSeen_c: cover property (rampStart ##[1:200] !rampBusy);
  secondSeen_c: cover property ($rose(secondActive));
  integOffSeen_c: cover property ($rose(integralOff));
endmodule
`default_nettype wire

// [testbench/gsr_servo_model.sv]
// Servo loop and input terminal model feeding the block's comparator
`timescale 1ns/10ps
`default_nettype none
module gsr_servo_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] quantitySel,
  input wire logic signed [15:0] level,
  input wire logic terminalReq,
  input wire logic signed [15:0] torqueReq,
  output logic gainInput,
  output logic [15:0] cmdPulseFreq,
  output logic signed [15:0] posDeviation,
  output logic signed [15:0] motorSpeed,
  output logic signed [15:0] torqueIn
);
  // Unselected quantities rest at zero; deviation and speed report negative
  // so only their magnitude can cross the level
  always_ff @(posedge clock) begin
    if (rst) begin
      gainInput <= 1'b0;
      cmdPulseFreq <= 16'h0000;
      posDeviation <= 16'sh0000;
      motorSpeed <= 16'sh0000;
      torqueIn <= 16'sh0000;
    end else begin
      gainInput <= terminalReq;
      cmdPulseFreq <= (quantitySel == 3'h3) ? level : 16'h0000;
      posDeviation <= (quantitySel == 3'h4) ? -level : 16'sh0000;
      motorSpeed <= (quantitySel == 3'h5) ? -level : 16'sh0000;
      torqueIn <= torqueReq;
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_gain_switch_resonance_filter.sv]
// Self-checking bench for the gain switch and torque filter block
`timescale 1ns/10ps
`default_nettype none
module tb_gain_switch_resonance_filter;
  import gsr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] sg1 = 16'h0032, it1 = 16'h012c, tc1 = 16'h0096;
  logic [15:0] pg1 = 16'h003c, sg2 = 16'h0096, it2 = 16'h2710;
  logic [15:0] tc2 = 16'h01f4, pg2 = 16'h003c;
  logic [11:0] nAf = 12'h5dc, nBf = 12'h5dc;
  logic [6:0] nAq = 7'h07, nAd = 7'h00, nBq = 7'h07, nBd = 7'h00;
  logic [2:0] sel = 3'h0, quantitySel = 3'h0;
  logic [14:0] thr = 15'h0064, hys = 15'h0005;
  logic [11:0] qdly = 12'h005, ramp = 12'h000;
  logic terminalReq = 1'b0;
  logic signed [15:0] level = 16'sh0000, torqueReq = 16'sh0000;
  logic gainInput, integralOff, secondActive, rampBusy, torqueOutValid;
  logic [15:0] cmdPulseFreq, speedGain, speedIntegralTc, torqueLpfTc, posGain;
  logic signed [15:0] posDeviation, motorSpeed, torqueIn, torqueOut;
  int errors = 0;
  int checked = 0;

  gsr_servo_model servo (.clock(clock), .rst(rst), .quantitySel(quantitySel),
    .level(level), .terminalReq(terminalReq), .torqueReq(torqueReq),
    .gainInput(gainInput), .cmdPulseFreq(cmdPulseFreq),
    .posDeviation(posDeviation), .motorSpeed(motorSpeed),
    .torqueIn(torqueIn));

  gsr_gain_switch_filter #(.CYCLES_PER_MS(20)) dut (.clock(clock), .rst(rst),
    .torqueIn(torqueIn), .speedGainFirst(sg1), .speedIntegralTcFirst(it1),
    .torqueLpfTcFirst(tc1), .posGainFirst(pg1), .speedGainSecond(sg2),
    .speedIntegralTcSecond(it2), .torqueLpfTcSecond(tc2),
    .posGainSecond(pg2), .notchAFreq(nAf), .notchAQuality(nAq),
    .notchADepth(nAd), .notchBFreq(nBf), .notchBQuality(nBq),
    .notchBDepth(nBd), .gainSwitchSelect(sel), .gainSwitchThreshold(thr),
    .gainSwitchHysteresis(hys), .gainSwitchQualifyDelay(qdly),
    .gainSwitchRampTime(ramp), .gainInput(gainInput),
    .cmdPulseFreq(cmdPulseFreq), .posDeviation(posDeviation),
    .motorSpeed(motorSpeed), .speedGain(speedGain),
    .speedIntegralTc(speedIntegralTc), .torqueLpfTc(torqueLpfTc),
    .posGain(posGain), .integralOff(integralOff),
    .secondActive(secondActive), .rampBusy(rampBusy),
    .torqueOut(torqueOut), .torqueOutValid(torqueOutValid));

  always #10 clock = ~clock;

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic fail(input string msg);
    errors++;
    $display("MISMATCH t=%0t %s", $time, msg);
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
    checked++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    checked++;
    if (got !== exp) fail($sformatf("%s got %b exp %b", msg, got, exp));
  endtask

  task automatic chkRange(input logic signed [15:0] got, input int lo,
                          input int hi, input string msg);
    checked++;
    if ($isunknown(got) || got < lo || got > hi)
      fail($sformatf("%s got %0d", msg, got));
  endtask

  task automatic waitSecond(input logic exp, input int bound);
    int i;
    i = 0;
    while (secondActive !== exp && i < bound) begin
      tick(1);
      i++;
    end
    chk1(secondActive, exp, "set change late");
  endtask

  task automatic holdSecond(input logic exp, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      tick(1);
      if (secondActive !== exp) break;
    end
    chk1(secondActive, exp, "set changed early");
  endtask

  task automatic waitValid(output int n);
    n = 0;
    while (torqueOutValid !== 1'b1 && n < 2600) begin
      tick(1);
      n++;
    end
    chk1(torqueOutValid, 1'b1, "no torque sample");
    tick(1);
    chk1(torqueOutValid, 1'b0, "valid too long");
  endtask

  task automatic test_reset();
    chk16(speedGain, 16'h0028, "reset speed gain");
    chk16(speedIntegralTc, 16'h00c8, "reset integral");
    chk16(torqueLpfTc, 16'h00c8, "reset filter tc");
    chk16(posGain, 16'h0028, "reset pos gain");
    chk1(secondActive, 1'b0, "reset set");
    chk1(rampBusy, 1'b0, "reset ramp");
    chk16(torqueOut, 16'h0000, "reset torque");
    chk1(integralOff, 1'b0, "reset integral cut");
    tick(1);
    rst = 1'b0;
    tick(3);
    chk16(torqueLpfTc, tc1, "first filter tc");
    chk16(speedGain, sg1, "first speed gain");
    $display("test_reset done");
  endtask

  task automatic test_clamp();
    tc1 = 16'h0001;
    tick(3);
    chk16(torqueLpfTc, 16'h000a, "tc floor");
    tc1 = 16'h2000;
    tick(3);
    chk16(torqueLpfTc, 16'h1388, "tc ceiling");
    tc1 = 16'h0096;
    tick(3);
    $display("test_clamp done");
  endtask

  task automatic test_fixed();
    qdly = 12'h002;
    sel = 3'h1;
    holdSecond(1'b0, 36);
    waitSecond(1'b1, 60);
    tick(3);
    chk16(speedGain, sg2, "second speed gain");
    chk16(speedIntegralTc, it2, "second integral");
    chk16(torqueLpfTc, tc2, "second filter tc");
    chk16(posGain, pg2, "second pos gain");
    chk1(integralOff, 1'b1, "integral cut");
    sel = 3'h0;
    waitSecond(1'b0, 80);
    tick(3);
    chk16(speedGain, sg1, "back to first");
    chk1(integralOff, 1'b0, "integral back");
    $display("test_fixed done");
  endtask

  task automatic test_input();
    qdly = 12'h003;
    sel = 3'h2;
    terminalReq = 1'b1;
    tick(40);
    terminalReq = 1'b0;
    holdSecond(1'b0, 120);
    terminalReq = 1'b1;
    waitSecond(1'b1, 110);
    terminalReq = 1'b0;
    waitSecond(1'b0, 110);
    $display("test_input done");
  endtask

  task automatic test_levels();
    int m;
    qdly = 12'h000;
    for (m = 3; m <= 5; m++) begin
      sel = 3'(m);
      quantitySel = 3'(m);
      level = 16'sh0064;
      holdSecond(1'b0, 40);
      level = 16'sh0065;
      waitSecond(1'b1, 50);
      level = 16'sh0060;
      holdSecond(1'b1, 50);
      level = 16'sh005f;
      waitSecond(1'b0, 50);
    end
    sel = 3'h0;
    level = 16'sh0000;
    tick(3);
    $display("test_levels done");
  endtask

  task automatic test_ramp();
    int k;
    int i;
    logic [15:0] prev;
    ramp = 12'h004;
    prev = speedGain;
    k = 0;
    i = 0;
    sel = 3'h1;
    waitSecond(1'b1, 50);
    tick(1);
    chk1(rampBusy, 1'b1, "ramp start");
    while (rampBusy === 1'b1 && i < 150) begin
      tick(1);
      i++;
      if (speedGain !== prev) begin
        k++;
        prev = speedGain;
        chk16(speedGain, 16'(50 + 25 * k), "ramp gain");
        chk16(torqueLpfTc, 16'(150 + 350 * k / 4), "ramp tc");
        chk16(posGain, 16'h003c, "ramp pos");
      end
    end
    chk16(16'(k), 16'h0004, "ramp steps");
    chk1(rampBusy, 1'b0, "ramp end");
    $display("test_ramp done");
  endtask

  task automatic test_torque();
    int n;
    tc2 = 16'h0001;
    torqueReq = 16'sd1000;
    tick(3);
    chk16(torqueLpfTc, 16'h0001, "second tc floor");
    repeat (6) waitValid(n);
    waitValid(n);
    chk16(16'(n + 1), 16'h09c4, "sample period");
    chkRange(torqueOut, 990, 1000, "filter settle");
    nAf = 12'hbb8;
    nAq = 7'h01;
    nAd = 7'h64;
    nBf = 12'hbb8;
    nBq = 7'h02;
    nBd = 7'h32;
    torqueReq = -16'sd1000;
    repeat (20) waitValid(n);
    chkRange(torqueOut, -1000, -970, "notch dc pass");
    $display("test_torque done");
  endtask

  task automatic conclude();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #1_600_000;
    fail("watchdog expired");
    conclude();
  end

  initial begin
    tick(16);
    test_reset();
    test_clamp();
    test_fixed();
    test_input();
    test_levels();
    test_ramp();
    test_torque();
    conclude();
  end
endmodule
`default_nettype wire
